// [rtl/evt_consts.svh]
`ifndef EVT_CONSTS_SVH
`define EVT_CONSTS_SVH

// register map of the serial control interface
`define EVT_CAUSE_ADDR 8'h05
`define LIVE_STAT_ADDR 8'h06
`define UNMAPPED_READ 8'h00

// event cause flag positions
`define FLG_REG_FAULT 7
`define FLG_WDT 6
`define FLG_SOFT_CRST 5
`define FLG_SOFT_OFF 4
`define FLG_MAN_RST 3
`define FLG_UVLO 2
`define FLG_OVLO 1
`define FLG_THERMAL_OVERLOAD_FLAG 0
`define EVT_CAUSE_RESET 8'h00

// soft control field codes
`define SOFT_CODE_CRST 2'b01
`define SOFT_CODE_OFF 2'b10

// live status reset values (bias ready, dropout 0/1, alarm high/low)
`define LIVE_IN_RESET 5'h10
`define IRQ_DRIVE_RESET 1'b0
`define EN_STABLE_RESET 1'b1

// interrupt flag vector width fed from the interrupt registers
`define INT_FLAG_W 16

// serial slave address, arbitrary value
`define DEV_ADDR 7'h48

// enable input debounce time and clock
`define CLK_PERIOD_NS 50
`define DEB_TIME_NS 30000
`define DEB_CYCLES ((`DEB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEB_CNT_W 10

`endif

// [rtl/evt_pkg.sv]
package evt_pkg;

  // one-cycle or level event requests from the supervisory logic
  typedef struct packed {
    logic regulator_fault;  // shutdown caused by a buck-boost channel fault
    logic wdt_expired;      // watchdog expiry acted on (off or reset)
    logic manual_reset;     // manual reset completed
    logic sys_undervolt;    // system supply under lockout threshold
    logic sys_overvolt;     // system supply over lockout threshold
    logic thermal_overload; // junction over overload threshold
  } event_in_t;

  // live comparator levels, asynchronous to clk
  typedef struct packed {
    logic bias_ready;
    logic first_ldo_dropout;
    logic second_ldo_dropout;
    logic thermal_alarm_high;
    logic thermal_alarm_low;
  } live_in_t;

  // serial engine states, one-hot
  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_addr = 7'h02,
    st_ack_addr = 7'h04,
    st_wr = 7'h08,
    st_ack_wr = 7'h10,
    st_rd = 7'h20,
    st_ack_rd = 7'h40
  } ser_state_t;

endpackage

// [rtl/event_cause_and_global_status.sv]
`timescale 1ns/100ps
`include "evt_consts.svh"
module event_cause_and_global_status #(
  parameter logic metal_option_id = 1'b1  // factory option, value arbitrary
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_drv,
  output logic sda_oe,
  input wire evt_pkg::event_in_t events,
  input wire logic [1:0] soft_control_field,
  input wire logic soft_action_done,
  input wire evt_pkg::live_in_t live,
  input wire logic enable_input_active_low,
  input wire logic [`INT_FLAG_W-1:0] int_flags,
  input wire logic [`INT_FLAG_W-1:0] int_masks,
  output logic interrupt_output_active_low_drv,
  output logic interrupt_output_active_low_oe
);
  import evt_pkg::*;

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic scl_m, scl_s, scl_d;  // scl meta, synced, delayed
  logic sda_m, sda_s, sda_d;  // sda meta, synced, delayed
  logic en_m, en_s;           // enable pin meta and synced
  live_in_t live_m, live_s;   // comparator levels

  // two flops per pin, plus a delayed third for scl and sda; the meta stage feeds no logic
  always_ff @(posedge clk) begin
    if (!nrst) begin
      // idle-high lines, so no false edge follows reset
      {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, en_m, en_s} <= 8'hff;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      en_m <= enable_input_active_low;
      en_s <= en_m;
    end
  end

  // comparator levels change slowly but are not clk related
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {live_m, live_s} <= {2{`LIVE_IN_RESET}};
    end else begin
      live_m <= live;
      live_s <= live_m;
    end
  end

  // bus conditions seen on the synced lines
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================
  // enable input debounce
  // ==========================================================
  logic en_stable;                   // debounced pin level
  logic [`DEB_CNT_W-1:0] deb_cnt;    // cycles the new level has held

  // a level must hold the full debounce time before it is taken;
  // any bounce restarts the count, so short glitches never show
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {en_stable, deb_cnt} <= {`EN_STABLE_RESET, `DEB_CNT_W'(0)};
    end else if (en_s == en_stable) begin
      deb_cnt <= '0;
    end else if (deb_cnt == `DEB_CNT_W'(`DEB_CYCLES - 1)) begin
      en_stable <= en_s;
      deb_cnt <= '0;
    end else begin
      deb_cnt <= deb_cnt + `DEB_CNT_W'(1);
    end
  end

  // ==========================================================
  // interrupt output drive
  // ==========================================================
  logic [`INT_FLAG_W-1:0] pend_prev;  // raw flags last cycle
  logic [`INT_FLAG_W-1:0] pend_now;   // unmasked flags this cycle
  logic irq_gate;                     // gate drive, high pulls pin low
  logic pend_rise;

  assign pend_now = int_flags & ~int_masks;
  assign pend_rise = |(pend_now & ~pend_prev);

  // assert on a flag going 0 to 1 while unmasked (unmasking a flag
  // already set is no new event); release only when every flag,
  // masked or not, is gone; a new rise beats the release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {pend_prev, irq_gate} <= {`INT_FLAG_W'(0), `IRQ_DRIVE_RESET};
    end else begin
      pend_prev <= int_flags;
      if (pend_rise) begin
        irq_gate <= 1'b1;
      end else if (int_flags == '0) begin
        irq_gate <= 1'b0;
      end
    end
  end

  // open drain: only ever drives low
  assign interrupt_output_active_low_drv = 1'b0;
  assign interrupt_output_active_low_oe = irq_gate;

  // ==========================================================
  // event cause flags
  // ==========================================================
  logic [7:0] event_cause_flags;  // sticky causes since last read
  logic [7:0] flag_set;           // causes raised this cycle
  logic rd_clear;                 // the flag byte is being sent

  always_comb begin
    flag_set = 8'h00;
    flag_set[`FLG_REG_FAULT] = events.regulator_fault;
    // both watchdog actions (off or reset) report the same cause
    flag_set[`FLG_WDT] = events.wdt_expired;
    flag_set[`FLG_SOFT_CRST] = soft_action_done
      & (soft_control_field == `SOFT_CODE_CRST);
    flag_set[`FLG_SOFT_OFF] = soft_action_done
      & (soft_control_field == `SOFT_CODE_OFF);
    flag_set[`FLG_MAN_RST] = events.manual_reset;
    flag_set[`FLG_UVLO] = events.sys_undervolt;
    flag_set[`FLG_OVLO] = events.sys_overvolt;
    flag_set[`FLG_THERMAL_OVERLOAD_FLAG] = events.thermal_overload;
  end

  // clear happens as the byte is captured for sending, so the host
  // sees exactly what is wiped; a set in that cycle survives
  always_ff @(posedge clk) begin
    if (!nrst) begin
      event_cause_flags <= `EVT_CAUSE_RESET;
    end else if (rd_clear) begin
      event_cause_flags <= flag_set;
    end else begin
      event_cause_flags <= event_cause_flags | flag_set;
    end
  end

  // ==========================================================
  // live status word
  // ==========================================================
  logic [7:0] global_live_status;
  assign global_live_status = {
    metal_option_id,
    live_s.bias_ready,
    live_s.first_ldo_dropout,
    live_s.second_ldo_dropout,
    live_s.thermal_alarm_high,
    live_s.thermal_alarm_low,
    ~en_stable,
    irq_gate
  };

  // ==========================================================
  // serial slave engine
  // ==========================================================
  ser_state_t state, next_state;
  logic [3:0] bitcnt, next_bitcnt;   // bits moved in current byte
  logic [7:0] shreg, next_shreg;     // receive shifter
  logic [7:0] tx, next_tx;           // transmit shifter
  logic [7:0] ptr, next_ptr;         // register pointer
  logic oe_r, next_oe;               // sda pull low
  logic rw, next_rw;                 // read transfer
  logic first, next_first;           // next written byte is pointer
  logic mack, next_mack;             // master acked last byte
  logic ld_tx;                       // read byte captured
  logic [7:0] read_word;             // byte at pointer

  // unmapped addresses read back zero
  always_comb begin
    unique case (ptr)
      `EVT_CAUSE_ADDR: read_word = event_cause_flags;
      `LIVE_STAT_ADDR: read_word = global_live_status;
      default: read_word = `UNMAPPED_READ;
    endcase
  end

  assign rd_clear = ld_tx & (ptr == `EVT_CAUSE_ADDR);

  // sampling on rising scl, driving after falling scl keeps sda
  // stable while scl is high; no clock stretching is done
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_tx = tx;
    next_ptr = ptr;
    next_oe = oe_r;
    next_rw = rw;
    next_first = first;
    next_mack = mack;
    ld_tx = 1'b0;
    if (stop_cond) begin
      next_state = st_idle;  // stop ends any transfer
      next_oe = 1'b0;
    end else if (start_cond) begin
      next_state = st_addr;  // start or repeated start
      next_bitcnt = 4'h0;
      next_oe = 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          next_oe = 1'b0;
        end
        st_addr: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            if (shreg[7:1] == `DEV_ADDR) begin
              next_state = st_ack_addr;  // acknowledge our address
              next_oe = 1'b1;
              next_rw = shreg[0];
            end else begin
              next_state = st_idle;  // other slave, stay off the bus
            end
          end
        end
        st_ack_addr: begin
          if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (rw) begin
              next_state = st_rd;
              ld_tx = 1'b1;
              next_tx = read_word;
              next_oe = ~read_word[7];
              next_ptr = ptr + 8'h01;
            end else begin
              next_state = st_wr;
              next_oe = 1'b0;
              next_first = 1'b1;
            end
          end
        end
        st_wr: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            next_state = st_ack_wr;
            next_oe = 1'b1;
            // later bytes are acked but dropped: registers are read only
            if (first) begin
              next_ptr = shreg;
              next_first = 1'b0;
            end
          end
        end
        st_ack_wr: begin
          if (scl_fall) begin
            next_state = st_wr;
            next_oe = 1'b0;
            next_bitcnt = 4'h0;
          end
        end
        st_rd: begin
          if (scl_rise) begin
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              next_state = st_ack_rd;  // free sda for master ack
              next_oe = 1'b0;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_oe = ~tx[6];
            end
          end
        end
        st_ack_rd: begin
          if (scl_rise) begin
            next_mack = ~sda_s;
          end else if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (mack) begin
              next_state = st_rd;  // burst continues at next address
              ld_tx = 1'b1;
              next_tx = read_word;
              next_oe = ~read_word[7];
              next_ptr = ptr + 8'h01;
            end else begin
              next_state = st_idle;  // nack: wait for stop
            end
          end
        end
      endcase
    end
  end

  // serial engine state registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= st_idle;
      {bitcnt, shreg, tx, ptr, oe_r, rw, first, mack} <= '0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      tx <= next_tx;
      ptr <= next_ptr;
      oe_r <= next_oe;
      rw <= next_rw;
      first <= next_first;
      mack <= next_mack;
    end
  end

  // open drain data line
  assign sda_drv = 1'b0;
  assign sda_oe = oe_r;

endmodule

// [sim/evt_sva.sv]
`timescale 1ns/100ps
`include "evt_consts.svh"
// ====
// pin-level checker
module evt_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_drv,
  input wire logic sda_oe,
  input wire logic [`INT_FLAG_W-1:0] int_flags,
  input wire logic [`INT_FLAG_W-1:0] int_masks,
  input wire logic interrupt_output_active_low_drv,
  input wire logic interrupt_output_active_low_oe
);
  logic [`INT_FLAG_W-1:0] last_flags; // flags one cycle back
  logic rise_now; // an unmasked flag went 0 to 1
  logic irq; // short alias of the pin pull-down
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // free running, so the first cycle after reset still has a history
  always_ff @(posedge clk) begin
    last_flags <= int_flags;
  end
  assign rise_now = |(int_flags & ~last_flags & ~int_masks);
  assign irq = interrupt_output_active_low_oe;
  sequence unmasked_rise;
    rise_now;
  endsequence
  // a bit driven low stays for at least four clk cycles
  sequence held_low;
    sda_oe [*4];
  endsequence
  irq_set_a: assert property (unmasked_rise |=> irq)
    else $error("irq not raised after flag rise");
  irq_quiet_a: assert property (!irq && !rise_now |=> !irq)
    else $error("irq raised without cause");
  irq_release_a: assert property (int_flags == '0 |=> !irq)
    else $error("irq kept with all flags clear");
  irq_hold_a: assert property (irq && int_flags != '0 |=> irq)
    else $error("irq dropped while flags set");
  irq_cause_a: assert property (irq |-> $past(int_flags) != '0)
    else $error("irq drive with no flag");
  open_drain_a: assert property (!sda_drv && !interrupt_output_active_low_drv)
    else $error("open drain value not low");
  sda_edge_a: assert property ($changed(sda_oe) |-> !scl)
    else $error("data changed while clock high");
  ack_hold_a: assert property ($rose(sda_oe) |-> held_low)
    else $error("driven bit not held");
endmodule

bind event_cause_and_global_status evt_sva chk (.clk(clk), .nrst(nrst), .scl(scl),
  .sda_drv(sda_drv), .sda_oe(sda_oe), .int_flags(int_flags), .int_masks(int_masks),
  .interrupt_output_active_low_drv(interrupt_output_active_low_drv),
  .interrupt_output_active_low_oe(interrupt_output_active_low_oe));

// [sim/i2c_host.sv]
`timescale 1ns/100ps
// ====
// serial host, pulled-up data line
module i2c_host (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda_in
);
  logic sda_m; // host side of the open-drain line
  int ph = 6; // clocks per quarter bit, raise for a slow host
  assign sda_in = sda_m & ~sda_oe;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hold();
    repeat (ph) @(posedge clk);
  endtask
  // one bit: data set while the clock is low, sampled mid high
  task automatic bit_io(input logic b, output logic v);
    sda_m <= b;
    hold();
    scl <= 1'b1;
    hold();
    v = sda_in;
    hold();
    scl <= 1'b0;
    hold();
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] r,
                         output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(ak, a);
  endtask
  // low level gives a start, high a stop
  task automatic cond(input logic lvl);
    sda_m <= !lvl;
    hold();
    scl <= 1'b1;
    hold();
    sda_m <= lvl;
    hold();
    if (!lvl) begin
      scl <= 1'b0;
      hold();
    end
  endtask
  // pointer write, repeated start, two bytes read
  task automatic read_pair(input logic [6:0] dev, input logic [7:0] ptr,
                           output logic [7:0] r0, output logic [7:0] r1, output logic [2:0] ak);
    logic [7:0] junk;
    logic a;
    @(posedge clk);
    cond(1'b0);
    byte_io({dev, 1'b0}, 1'b1, junk, ak[2]);
    byte_io(ptr, 1'b1, junk, ak[1]);
    cond(1'b0);
    byte_io({dev, 1'b1}, 1'b1, junk, ak[0]);
    byte_io(8'hff, 1'b0, r0, a);
    byte_io(8'hff, 1'b1, r1, a);
    cond(1'b1);
  endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/100ps
`include "evt_consts.svh"
// ====
// bench top
module tb_top;
  import evt_pkg::*;
  localparam logic metal_id = 1'b1; // factory option, value arbitrary
  logic clk = 1'b0;
  logic nrst, scl, sda_in, sda_drv, sda_oe, done, en_n, irq_drv, irq_oe, en_act, irq_exp;
  event_in_t ev;
  live_in_t live;
  logic [1:0] code;
  logic [`INT_FLAG_W-1:0] flags, masks;
  logic [7:0] exp_f, b0, b1, r0;
  logic [2:0] acks;
  logic [31:0] rnd = 32'h836c;
  int num_errors = 0;
  int checks = 0;
  always #25 clk = ~clk;
  event_cause_and_global_status #(.metal_option_id(metal_id)) uut (.clk(clk), .nrst(nrst),
    .scl(scl), .sda_in(sda_in), .sda_drv(sda_drv), .sda_oe(sda_oe), .events(ev),
    .soft_control_field(code), .soft_action_done(done), .live(live),
    .enable_input_active_low(en_n), .int_flags(flags), .int_masks(masks),
    .interrupt_output_active_low_drv(irq_drv), .interrupt_output_active_low_oe(irq_oe));
  i2c_host host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));
  // ====
  // expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] cause_bits(input event_in_t e, input logic [1:0] c,
                                            input logic d);
    return {e.regulator_fault, e.wdt_expired, d && c == 2'b01, d && c == 2'b10,
            e.manual_reset, e.sys_undervolt, e.sys_overvolt, e.thermal_overload};
  endfunction
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one-cycle request, expectation accumulates until the next read
  task automatic fire(input event_in_t e, input logic [1:0] c, input logic d);
    @(posedge clk);
    ev <= e;
    code <= c;
    done <= d;
    @(posedge clk);
    ev <= '0;
    done <= 1'b0;
    exp_f = exp_f | cause_bits(e, c, d);
  endtask
  task automatic rd_check(input string name);
    host.read_pair(`DEV_ADDR, 8'h05, b0, b1, acks);
    check("acks", 8'h00, {5'h00, acks});
    check("cause", exp_f, b0);
    check("status", {metal_id, live, en_act, irq_exp}, b1);
    exp_f = 8'h00;
    $display("test %s finished", name);
  endtask
  task automatic irq_step(input logic [15:0] f, input logic [15:0] m, input logic e);
    @(posedge clk);
    flags <= f;
    masks <= m;
    repeat (3) @(posedge clk);
    irq_exp = e;
    check("irq", {7'h00, e}, {7'h00, irq_oe});
  endtask
  // a hang counts as a mismatch
  initial begin
    repeat (95000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  // ====
  // main sequence
  initial begin
    {nrst, ev, code, done, flags, masks, exp_f, en_act, irq_exp} = '0;
    live = 5'h10;
    en_n = 1'b1;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    rd_check("reset");
    for (int i = 0; i < 6; i++) begin
      fire(event_in_t'(6'h01 << i), 2'b00, 1'b0);
      rd_check("cause");
    end
    for (int c = 0; c < 4; c++) begin
      fire('0, c[1:0], 1'b1);
      rd_check("soft");
    end
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      live <= rnd[13:9];
      fire(event_in_t'(rnd[5:0]), rnd[7:6], rnd[8]);
      rnd = lfsr(rnd);
      fire(event_in_t'(rnd[5:0]), rnd[7:6], rnd[8]);
      rd_check("random");
    end
    host.read_pair(`DEV_ADDR, 8'h04, b0, b1, acks);
    check("unmapped", 8'h00, b0);
    check("next", 8'h00, b1);
    host.read_pair(`DEV_ADDR ^ 7'h01, 8'h05, b0, b1, acks);
    check("foreign", 8'hff, {acks, b0[4:0]});
    $display("test unmapped finished");
    for (int k = 680; k < 700; k++) begin
      fork
        host.read_pair(`DEV_ADDR, 8'h05, r0, b1, acks);
        begin
          repeat (k) @(posedge clk);
          ev <= event_in_t'(6'h01);
          @(posedge clk);
          ev <= '0;
        end
      join
      host.read_pair(`DEV_ADDR, 8'h05, b0, b1, acks);
      check("kept", 8'h01, (r0 ^ b0) & 8'h01);
    end
    $display("test kept finished");
    en_n <= 1'b0;
    repeat (700) @(posedge clk);
    en_act = 1'b1;
    rd_check("enable");
    en_n <= 1'b1;
    repeat (300) @(posedge clk);
    en_n <= 1'b0;
    rd_check("glitch");
    en_n <= 1'b1;
    repeat (700) @(posedge clk);
    en_act = 1'b0;
    irq_step(16'h0001, 16'h0000, 1'b1);
    rd_check("irq");
    irq_step(16'h0000, 16'h0000, 1'b0);
    irq_step(16'h0002, 16'h0002, 1'b0);
    irq_step(16'h0003, 16'h0002, 1'b1);
    irq_step(16'h0000, 16'h0002, 1'b0);
    fire(event_in_t'(6'h3f), 2'b00, 1'b0);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    exp_f = 8'h00;
    repeat (5) @(posedge clk);
    rd_check("second reset");
    complete_run();
  end
endmodule
